// ==== hdl/hsg_gate_ctrl.sv ====
/*
  Gate current selection, FET drive enable and power-good logic of a hot-swap controller.
  Assumes comparator results and quick-select pins are asynchronous levels, high when true.
*/
// Overview of operation
// - Drive FET only without OC, UV, OV faults
// - Current setting is (code plus one) times ten
// - Code resets to 0100, fifty microamps
// - Quick-select: 00 code, 01/10/11 fixed currents
// - Unconnected quick-select pins read as 00
// - Quick-select changes take effect three cycles later
// - Host code writes apply to current selection with quick-select 00
// - Power-good needs all five conditions true
// - Drain above one volt blocks power-good
// - Drive held off from reset until conditions
// - Overcurrent kills drive, power-good, sets flag
module hsg_gate_ctrl
  import hsg_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic overcurrent,
  input wire logic undervoltage,
  input wire logic overvoltage,
  input wire logic gate_above_vdd_m1,
  input wire logic drain_below_vee_p1,
  input wire logic quick_current_sel_hi,
  input wire logic quick_current_sel_lo,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic fet_drive_en,
  output logic power_good_n,
  output logic [CODE_W-1:0] gate_current_sel,
  output logic overcurrent_fault_flag,
  output logic irq
);

  logic [6:0] sync1_reg;
  // Drive stays off until the synchronisers hold real pin values.
  logic [1:0] arm_reg;
  logic [6:0] sync2_reg;
  logic [CODE_W-1:0] charge_current_code;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic pg_prev_reg;

  // Two-stage synchronisers for comparators and pins.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      arm_reg <= 2'h0;
    end
    else
    begin
      arm_reg <= {arm_reg[0], 1'b1};
      sync1_reg <= {quick_current_sel_hi, quick_current_sel_lo, drain_below_vee_p1,
                    gate_above_vdd_m1, overvoltage, undervoltage, overcurrent};
      sync2_reg <= sync1_reg;
    end
  end

  wire oc_s = sync2_reg[0];
  wire uv_s = sync2_reg[1];
  wire ov_s = sync2_reg[2];
  wire gate_ok_s = sync2_reg[3];
  wire drain_ok_s = sync2_reg[4];
  // Pins are expected to have pull-downs, so floating pins read 00.
  wire [1:0] qsel_s = sync2_reg[6:5];

  wire fault = oc_s | uv_s | ov_s;
  wire drive_next = ~fault & arm_reg[1];
  wire pg_next = ~fault & arm_reg[1] & gate_ok_s & drain_ok_s;

  logic [CODE_W-1:0] sel_next;
  always_comb
  begin
    case (qsel_s)
      QS_10UA: sel_next = CODE_MIN;
      QS_70UA: sel_next = CODE_70UA;
      QS_150UA: sel_next = CODE_150UA;
      default: sel_next = charge_current_code;
    endcase
  end

  wire wr_code = reg_write && reg_addr == ADDR_CODE;
  wire wr_en = reg_write && reg_addr == ADDR_IRQ_EN;
  wire wr_iclr = reg_write && reg_addr == ADDR_IRQ_CLR;
  wire wr_fclr = reg_write && reg_addr == ADDR_FLAG_CLR;
  wire [IRQ_W-1:0] irq_set = {pg_prev_reg & ~pg_next, ~pg_prev_reg & pg_next, oc_s};
  wire [IRQ_W-1:0] iclr_mask = wr_iclr ? reg_wdata[IRQ_W-1:0] : '0;

  logic [7:0] rdata_next;
  always_comb
  begin
    if (reg_addr == ADDR_CODE)
      rdata_next = {4'h0, charge_current_code};
    else if (reg_addr == ADDR_STATUS)
      rdata_next = {fet_drive_en, ~power_good_n, overcurrent_fault_flag, fet_drive_en,
                    gate_current_sel};
    else if (reg_addr == ADDR_IRQ_STAT)
      rdata_next = {5'h00, irq_stat_reg};
    else if (reg_addr == ADDR_IRQ_EN)
      rdata_next = {5'h00, irq_en_reg};
    else
      rdata_next = 8'h00;
  end

  // Drive, power-good and current select are re-evaluated every cycle.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fet_drive_en <= 1'b0;
      power_good_n <= 1'b1;
      gate_current_sel <= CODE_RESET;
      pg_prev_reg <= 1'b0;
    end
    else
    begin
      fet_drive_en <= drive_next;
      power_good_n <= ~pg_next;
      gate_current_sel <= sel_next;
      pg_prev_reg <= pg_next;
    end
  end

  // Register file; hardware set wins over software clear.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      charge_current_code <= CODE_RESET;
      overcurrent_fault_flag <= 1'b0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (wr_code)
        charge_current_code <= reg_wdata[CODE_W-1:0];
      if (oc_s)
        overcurrent_fault_flag <= 1'b1;
      else if (wr_fclr)
        overcurrent_fault_flag <= 1'b0;
      if (wr_en)
        irq_en_reg <= reg_wdata[IRQ_W-1:0];
      irq_stat_reg <= (irq_stat_reg & ~iclr_mask) | irq_set;
      irq <= |(((irq_stat_reg & ~iclr_mask) | irq_set) & irq_en_reg);
      reg_rdata <= reg_read ? rdata_next : 8'h00;
    end
  end
endmodule : hsg_gate_ctrl

// ==== hdl/hsg_pkg.sv ====
/*
  Constants for the hot-swap gate current and power-good logic.
  Assumes a 50 MHz system clock and a simple strobed register port.
*/
package hsg_pkg;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_RESET = 4'h4;
  localparam logic [3:0] CODE_MIN = 4'h0;
  localparam logic [3:0] CODE_70UA = 4'h6;
  localparam logic [3:0] CODE_150UA = 4'he;
  localparam int UA_STEP = 10;
  localparam logic [1:0] QS_PROG = 2'h0;
  localparam logic [1:0] QS_10UA = 2'h1;
  localparam logic [1:0] QS_70UA = 2'h2;
  localparam logic [1:0] QS_150UA = 2'h3;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
  localparam logic [3:0] ADDR_FLAG_CLR = 4'h5;
  localparam int IRQ_W = 3;
  localparam int IRQ_OC = 0;
  localparam int IRQ_PG_RISE = 1;
  localparam int IRQ_PG_FALL = 2;
  localparam int ST_DRIVE = 0;
  localparam int ST_PGOOD = 1;
  localparam int ST_OCFLAG = 2;
  localparam int ST_SEL_LO = 3;
  localparam int SEL_W = 4;
endpackage : hsg_pkg

// ==== testbench/hsg_fet_model.sv ====
/* Behavioural FET with gate and drain comparators, quick or slow to charge.
   Assumes the design drives fet_drive_en and the bench picks lag and drain_fault. */
module hsg_fet_model (
  input wire logic clock,
  input wire logic fet_drive_en,
  input wire logic drain_fault,
  input wire logic lag,
  output logic gate_above_vdd_m1,
  output logic drain_below_vee_p1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ramp_reg;
  always @(posedge clock) ramp_reg <= {ramp_reg[1:0], fet_drive_en};
  assign gate_above_vdd_m1 = fet_drive_en & ramp_reg[{lag, 1'b0}];
  assign drain_below_vee_p1 = gate_above_vdd_m1 & !drain_fault;
endmodule : hsg_fet_model

// ==== testbench/hsg_gate_ctrl_properties.sv ====
/* Port checks of the gate current and power-good logic.
   Assumes inputs reach the outputs three edges after they change. */
module hsg_gate_ctrl_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic overcurrent,
  input wire logic quick_current_sel_hi,
  input wire logic quick_current_sel_lo,
  input wire logic fet_drive_en,
  input wire logic power_good_n,
  input wire logic [3:0] gate_current_sel,
  input wire logic overcurrent_fault_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [1:0] qs = {quick_current_sel_hi, quick_current_sel_lo};
  drive_off_a: assert property (overcurrent [*4] |-> !fet_drive_en) else $error("drive");
  pgood_off_a: assert property (overcurrent [*4] |-> power_good_n) else $error("pgood");
  flag_set_a: assert property (overcurrent [*4] |-> overcurrent_fault_flag) else $error("flag");
  pgood_drive_a: assert property (!fet_drive_en |-> power_good_n) else $error("pg");
  drive_rise_a: assert property ($rose(fet_drive_en) |-> !$past(overcurrent, 3)) else $error("on");
  sel_low_a: assert property ((qs == 2'h1) [*4] |-> gate_current_sel == 4'h0) else $error("s1");
  sel_mid_a: assert property ((qs == 2'h2) [*4] |-> gate_current_sel == 4'h6) else $error("s2");
  sel_high_a: assert property ((qs == 2'h3) [*4] |-> gate_current_sel == 4'he) else $error("s3");
endmodule : hsg_gate_ctrl_properties

bind hsg_gate_ctrl hsg_gate_ctrl_properties i_props (.*);

// ==== testbench/hsg_gate_ctrl_tb.sv ====
/* Random bench of the gate current and power-good logic.
   Assumes hsg_fet_model answers on the comparators. */
module hsg_gate_ctrl_tb;
  import hsg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset_n = 0, overcurrent = 0, undervoltage = 0, overvoltage = 0, lag = 0;
  logic quick_current_sel_hi = 0, quick_current_sel_lo = 0, reg_write = 0, reg_read = 0, irq;
  logic drain_fault = 0, po = 0, bad, gate_above_vdd_m1, drain_below_vee_p1, power_good_n;
  logic fet_drive_en, overcurrent_fault_flag;
  logic [3:0] reg_addr = 0, gate_current_sel, code = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [31:0] rnd = 32'h44;
  int mismatches = 0, checks_done = 0, cyc = 0;
  hsg_gate_ctrl i_dut (.*);
  hsg_fet_model i_fet (.*);
  initial forever #10 clock = ~clock;
  always @(posedge clock) if (++cyc == 3000) final_report(1);
  function automatic logic [31:0] next(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : next
  function automatic logic [3:0] exp_sel(logic [1:0] q);
    return q == 2'h0 ? code : q == 2'h1 ? 4'h0 : q == 2'h2 ? 4'h6 : 4'he;
  endfunction : exp_sel
  task automatic chk(logic [7:0] e, logic [7:0] s, string n);
    checks_done++;
    mismatches += int'(s !== e);
    if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
  endtask : chk
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clock);
    {reg_write, reg_read} <= 2'h0;
    @(posedge clock);
    if (!w) chk(d, reg_rdata, "rdata");
  endtask : bus
  task automatic final_report(int extra);
    mismatches += extra;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (12) @(posedge clock);
    reset_n <= 1;
    repeat (2) @(posedge clock);
    chk(8'h00, fet_drive_en, "drive");
    bus(0, ADDR_CODE, 8'h04);
    bus(0, 4'hf, 8'h00);
    for (int i = 0; i < 80; i++)
    begin
      rnd = next(rnd);
      code = i < 16 ? 4'(i) : rnd[15:12];
      {overcurrent, undervoltage, overvoltage, drain_fault} <= rnd[3:0] & {4{rnd[4] & i > 15}};
      {quick_current_sel_hi, quick_current_sel_lo, lag} <= rnd[7:5] & {3{i > 15}};
      bus(1, ADDR_CODE, {4'h0, code});
      repeat (12) @(posedge clock);
      bad = overcurrent | undervoltage | overvoltage;
      chk(!bad, fet_drive_en, "drive");
      chk(bad | drain_fault, power_good_n, "pgood_n");
      chk(overcurrent | po, overcurrent_fault_flag, "flag");
      chk(exp_sel({quick_current_sel_hi, quick_current_sel_lo}), gate_current_sel, "sel");
      chk(8'h00, irq, "irq");
      bus(1, ADDR_FLAG_CLR, 8'h00);
      po = overcurrent;
    end
    {overcurrent, undervoltage, overvoltage} <= 3'h0;
    repeat (6) @(posedge clock);
    bus(1, ADDR_IRQ_CLR, 8'h07);
    bus(1, ADDR_IRQ_EN, 8'h01);
    repeat (2) @(posedge clock);
    chk(8'h00, irq, "irq");
    overcurrent <= 1;
    repeat (4) @(posedge clock);
    overcurrent <= 0;
    repeat (6) @(posedge clock);
    chk(8'h01, irq, "irq");
    chk(8'h01, overcurrent_fault_flag, "flag");
    bus(1, ADDR_IRQ_CLR, 8'h07);
    @(posedge clock);
    chk(8'h00, irq, "irq");
    final_report(0);
  end
endmodule : hsg_gate_ctrl_tb
